// File: inc/frs_pkg.sv
// Shared constants and types of the fault reaction supervisor.
// Assumes a single core clock; every other clock is sampled as data.
package frs_pkg;

  // ****************************************
  // Serial frame layout
  // ****************************************
  // Bits per frame and the clock count that a good frame carries
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_CLOCKS = 5'h10;
  // Field positions inside a received frame
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int DATA_MSB = 11;
  localparam int DATA_LSB = 4;
  // Command identifiers
  localparam logic [3:0] CMD_READ_POWER = 4'h1;
  localparam logic [3:0] CMD_READ_SYSTEM = 4'h2;
  localparam logic [3:0] CMD_READ_CAPTURE = 4'h3;
  localparam logic [3:0] CMD_READ_SERIAL = 4'h4;
  localparam logic [3:0] CMD_WRITE_LOW_POWER = 4'h5;
  // Key that sends the device to low power off
  localparam logic [7:0] LOW_POWER_KEY = 8'hAA;

  // ****************************************
  // Register fields and reset values
  // ****************************************
  localparam int PWR_REG_FAIL_BIT = 6;
  localparam int CAP_OVER_BIT = 4;
  localparam int SER_CLOCK_BIT = 2;
  localparam int SER_CMDID_BIT = 1;
  localparam int SER_PARITY_BIT = 0;
  localparam int SYS_POR_BIT = 1;
  localparam int SYS_REGCLK_BIT = 0;
  localparam logic [7:0] POWER_STATUS_RESET = 8'h00;
  localparam logic [1:0] SYSTEM_STATUS_RESET = 2'h2;
  localparam logic [4:0] CAPTURE_RESET = 5'h00;
  localparam logic [2:0] SERIAL_STATUS_RESET = 3'h0;
  // Idle level of the serial pins {clock, select, data}
  localparam logic [2:0] PIN_IDLE = 3'h2;

  // ****************************************
  // Device state machine
  // ****************************************
  typedef enum logic [7:0] {
    FRS_INIT = 8'h01,
    FRS_SELF_TEST = 8'h02,
    FRS_THRESH_CHECK = 8'h04,
    FRS_RAMP = 8'h08,
    FRS_ACTIVE = 8'h10,
    FRS_ERROR = 8'h20,
    FRS_LOW_POWER_OFF = 8'h40,
    FRS_SHUTDOWN = 8'h80
  } frs_state_type;

endpackage : frs_pkg

// File: inc/frs_ser_if.sv
// Carrier between the serial receiver and the supervisor core.
// Assumes both ends run on the core clock.
interface frs_ser_if;
  // One-cycle pulse when the select line rises
  logic frame_done;
  // Bits shifted in during the frame, first bit at the top
  logic [15:0] frame_bits;
  // Rising clock edges seen, saturating
  logic [4:0] edge_count;
  // Level sent before the first clock edge
  logic fault_summary;
  // Word returned during the next frame
  logic [15:0] response;

  modport rx (output frame_done, frame_bits, edge_count, input fault_summary, response);
  modport core (input frame_done, frame_bits, edge_count, output fault_summary, response);
endinterface : frs_ser_if

// File: hw/frs_serial_rx.sv
// Serial slave front end: samples the link pins and frames bits.
// Assumes the link clock is far slower than the core clock.
module frs_serial_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck_pin,
  input wire logic csn_pin,
  input wire logic sdi_pin,
  output logic sdo,
  output logic sdo_oe,
  frs_ser_if.rx ser
);

  // ****************************************
  // Pin sampling
  // ****************************************
  logic [2:0] s0, s1, s2; // Three stage samplers {clock, select, data}
  logic [2:0] filt; // Level once two late stages agree
  logic [2:0] prev; // Filtered level one cycle earlier
  logic [4:0] cnt; // Clock edges in this frame
  logic [15:0] rx_sh; // Incoming shift register
  logic [15:0] tx_sh; // Outgoing shift register
  logic in_frame, csn_fall, csn_rise, sck_rise, sck_fall;

  // Glitches shorter than a core cycle never reach the filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s0 <= frs_pkg::PIN_IDLE;
      s1 <= frs_pkg::PIN_IDLE;
      s2 <= frs_pkg::PIN_IDLE;
      filt <= frs_pkg::PIN_IDLE;
      prev <= frs_pkg::PIN_IDLE;
    end else begin
      s0 <= {sck_pin, csn_pin, sdi_pin};
      s1 <= s0;
      s2 <= s1;
      filt <= (filt & (s1 ^ s2)) | (s2 & ~(s1 ^ s2));
      prev <= filt;
    end
  end

  assign in_frame = ~filt[1];
  assign csn_fall = prev[1] & ~filt[1];
  assign csn_rise = ~prev[1] & filt[1];
  assign sck_rise = in_frame & filt[2] & ~prev[2];
  assign sck_fall = in_frame & ~filt[2] & prev[2];
  // Data line is driven only while selected
  assign sdo_oe = in_frame;

  // ****************************************
  // Framing
  // ****************************************
  // Shift in on rising edges, shift out on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h00;
      rx_sh <= 16'h0000;
      tx_sh <= 16'h0000;
      sdo <= 1'b0;
    end else if (csn_fall) begin
      cnt <= 5'h00;
      rx_sh <= 16'h0000;
      tx_sh <= ser.response;
      // RULE17 summary bit first
      sdo <= ser.fault_summary;
    end else begin
      if (sck_rise) begin
        rx_sh <= {rx_sh[14:0], filt[0]};
        cnt <= (cnt == 5'h1F) ? cnt : 5'(cnt + 5'h01);
      end
      // The summary bit stands until the first falling edge after a rise
      if (sck_fall && cnt != 5'h00) begin
        sdo <= tx_sh[15];
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
    end
  end

  // Frame result, held until the next frame ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser.frame_done <= 1'b0;
      ser.frame_bits <= 16'h0000;
      ser.edge_count <= 5'h00;
    end else begin
      ser.frame_done <= csn_rise;
      if (csn_rise) begin
        ser.frame_bits <= rx_sh;
        ser.edge_count <= cnt;
      end
    end
  end

  // Summary bit reaches the data line right after selection
  chk_summary_bit: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    csn_fall |=> sdo == $past(ser.fault_summary) && sdo_oe) else $error("summary bit not driven");
  chk_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ser.frame_done |=> !ser.frame_done) else $error("frame done longer than one cycle");
  cov_full_frame: cover property (@(posedge clk) disable iff (!rst_n) csn_rise && cnt == frs_pkg::FRAME_CLOCKS);

endmodule : frs_serial_rx

// File: hw/frs_supervisor.sv
// Fault reaction and reset supervisor of a power management device.
// Assumes analog comparators and clock monitors arrive as raw levels.
// What this block does
// RULE1: Regulator clock loss in threshold check: low power off
// RULE2: Regulator clock loss when active: error, count, flag
// RULE3: Low power clock loss: shutdown, reinit, resets low
// RULE4: Core supply fault: power-on flag, shutdown
// RULE5: Regulator undervoltage in init: self test, flag
// RULE6: Regulator undervoltage in threshold check: low power off
// RULE7: Regulator undervoltage in ramp: error, flag, resets low
// RULE8: Regulator undervoltage when active: flag, error
// RULE9: Regulator flag clears after read, fault gone
// RULE10: Overtemperature in start-up: error, count, hold reset
// RULE11: Overtemperature when active: reset, error, count, hold
// RULE12: External supply chosen only active, with hysteresis
// RULE13: Invalid state codes restart from init
// RULE14: System reset released only after power-up
// RULE15: Peripheral reset follows system reset after watchdog
// RULE16: Critical error: resets low, error, count
// RULE17: Summary bit driven before first serial clock
// RULE18: Summary bit is OR of power status
// RULE19: Capture clock count minus one, over-16 flag
// RULE20: Flag wrong clock count and unknown command
// RULE21: Frames must have odd parity, else flagged
// RULE22: Key 0xAA forces low power off
// RULE23: Error count at limit: low power off
// RULE24: Serial flags sticky; bad frames run no command
// RULE25: Error counter saturates, cleared by power-on only
module frs_supervisor #(
  parameter int ERR_W = 4, // Error counter width
  parameter logic [ERR_W-1:0] RESET_COUNT_LIMIT = 4'h7 // Error count at which retrying stops
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic SCK,
  input wire logic CSN,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic WATCHDOG_TRIGGER,
  input wire logic WAKE,
  input wire logic SELF_TEST_OK,
  input wire logic THRESH_OK,
  input wire logic RAMP_DONE,
  input wire logic REG_CLK_FAIL,
  input wire logic LOW_POWER_CLK_FAIL,
  input wire logic CORE_SUPPLY_FAULT,
  input wire logic INT_REG_UNDERVOLT,
  input wire logic INT_REG_OVERTEMP,
  input wire logic CRITICAL_ERROR,
  input wire logic EXT_SUPPLY_ABOVE_HIGH,
  input wire logic EXT_SUPPLY_BELOW_LOW,
  input wire logic [7:0] RAIL_FAULT,
  output logic SYSTEM_RESET_N,
  output logic PERIPHERAL_RESET_N,
  output logic REG_ENABLE,
  output logic EXT_SUPPLY_SELECT,
  output logic [7:0] STATE,
  output logic [ERR_W-1:0] ERROR_COUNT
);

  // ****************************************
  // Input sampling
  // ****************************************
  localparam int NPIN = 21; // Status pins that cross into the core domain
  logic [NPIN-1:0] pin_raw; // Raw pin levels
  logic [NPIN-1:0] pin_s; // Filtered levels
  logic wdog, wake, st_ok, thr_ok, ramp_ok, rc_fail, lp_fail, core_fault;
  logic uv, ot, crit, ext_hi, ext_lo;
  logic [7:0] rail; // Rail faults feeding power status

  assign pin_raw = {RAIL_FAULT, EXT_SUPPLY_BELOW_LOW, EXT_SUPPLY_ABOVE_HIGH, CRITICAL_ERROR,
    INT_REG_OVERTEMP, INT_REG_UNDERVOLT, CORE_SUPPLY_FAULT, LOW_POWER_CLK_FAIL, REG_CLK_FAIL,
    RAMP_DONE, THRESH_OK, SELF_TEST_OK, WAKE, WATCHDOG_TRIGGER};
  assign {rail, ext_lo, ext_hi, crit, ot, uv, core_fault, lp_fail, rc_fail, ramp_ok, thr_ok, st_ok,
    wake, wdog} = pin_s;

  // Three stages per pin; a change counts once stages two and three agree
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic [2:0] sh;
    logic q;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
        sh <= 3'h0;
        q <= 1'b0;
      end else begin
        sh <= {sh[1:0], pin_raw[i]};
        if (sh[1] == sh[2]) begin
          q <= sh[2];
        end
      end
    end
    assign pin_s[i] = q;
  end

  // Edge history for watchdog and wake
  logic wdog_prev, wake_prev, wdog_rise, wake_rise;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wdog_prev <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      wdog_prev <= wdog;
      wake_prev <= wake;
    end
  end
  assign wdog_rise = wdog & ~wdog_prev;
  assign wake_rise = wake & ~wake_prev;

  // ****************************************
  // Serial front end and frame checks
  // ****************************************
  frs_ser_if ser ();
  frs_serial_rx u_rx (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .sck_pin(SCK),
    .csn_pin(CSN),
    .sdi_pin(SDI),
    .sdo(SDO),
    .sdo_oe(SDO_OE),
    .ser(ser.rx)
  );

  logic [3:0] cmd; // Command field of the last frame
  logic [7:0] data; // Data field of the last frame
  logic count_bad, parity_bad, cmd_bad, frame_ok;
  assign cmd = ser.frame_bits[frs_pkg::CMD_MSB:frs_pkg::CMD_LSB];
  assign data = ser.frame_bits[frs_pkg::DATA_MSB:frs_pkg::DATA_LSB];
  // RULE20 clock count check
  assign count_bad = ser.edge_count != frs_pkg::FRAME_CLOCKS;
  // RULE21 odd parity is correct
  assign parity_bad = ~^ser.frame_bits;
  assign cmd_bad = cmd < frs_pkg::CMD_READ_POWER || cmd > frs_pkg::CMD_WRITE_LOW_POWER;
  // RULE24 damaged frames run no command
  assign frame_ok = ser.frame_done && !count_bad && !parity_bad && !cmd_bad;

  // ****************************************
  // Status registers
  // ****************************************
  logic [7:0] power_status; // Sticky rail and regulator faults
  logic [1:0] system_status; // Power-on and regulator clock flags
  logic [4:0] capture; // Clock count capture
  logic [2:0] serial_status; // Serial error flags
  logic lp_req; // Low power key accepted
  frs_pkg::frs_state_type state, next_state;
  logic shut; // Internal power-on reset while in shutdown

  assign shut = state == frs_pkg::FRS_SHUTDOWN;
  // RULE18 summary of all power faults
  assign ser.fault_summary = |power_status;

  // RULE9 a read keeps only faults still present; a live fault wins except in shutdown
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      power_status <= frs_pkg::POWER_STATUS_RESET;
    end else if (shut) begin
      power_status <= frs_pkg::POWER_STATUS_RESET;
    end else if (frame_ok && cmd == frs_pkg::CMD_READ_POWER) begin
      power_status <= {rail[7], uv, rail[5:0]};
    end else begin
      // RULE5 RULE6 RULE7 RULE8 regulator fault flag
      power_status <= power_status | {rail[7], uv, rail[5:0]};
    end
  end

  // Power-on flag survives shutdown; both bits clear on read, set wins
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      system_status <= frs_pkg::SYSTEM_STATUS_RESET;
    end else begin
      if (frame_ok && cmd == frs_pkg::CMD_READ_SYSTEM) begin
        system_status <= 2'h0;
      end
      // RULE3 RULE4 power-on flag
      if (lp_fail || core_fault) begin
        system_status[frs_pkg::SYS_POR_BIT] <= 1'b1;
      end
      // RULE2 regulator clock flag
      if (state == frs_pkg::FRS_ACTIVE && rc_fail) begin
        system_status[frs_pkg::SYS_REGCLK_BIT] <= 1'b1;
      end
    end
  end

  // Capture and serial flags follow every frame, even bad ones
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      capture <= frs_pkg::CAPTURE_RESET;
      serial_status <= frs_pkg::SERIAL_STATUS_RESET;
    end else if (shut) begin
      capture <= frs_pkg::CAPTURE_RESET;
      serial_status <= frs_pkg::SERIAL_STATUS_RESET;
    end else if (ser.frame_done) begin
      // RULE19 count minus one and overflow
      capture <= {ser.edge_count > frs_pkg::FRAME_CLOCKS, 4'(ser.edge_count - 5'h01)};
      // RULE24 sticky until read, new errors win
      serial_status <= ((frame_ok && cmd == frs_pkg::CMD_READ_SERIAL) ? 3'h0 : serial_status)
        | {count_bad, cmd_bad && !count_bad && !parity_bad, parity_bad};
    end
  end

  // Reply for the next frame; the low power key is taken from good frames only
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ser.response <= 16'h0000;
      lp_req <= 1'b0;
    end else begin
      // RULE22 key forces low power off
      lp_req <= frame_ok && cmd == frs_pkg::CMD_WRITE_LOW_POWER && data == frs_pkg::LOW_POWER_KEY;
      if (frame_ok) begin
        case (cmd)
          frs_pkg::CMD_READ_POWER: ser.response <= {8'h00, power_status};
          frs_pkg::CMD_READ_SYSTEM: ser.response <= {14'h0000, system_status};
          frs_pkg::CMD_READ_CAPTURE: ser.response <= {11'h000, capture};
          frs_pkg::CMD_READ_SERIAL: ser.response <= {13'h0000, serial_status};
          default: ser.response <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // Device state machine
  // ****************************************
  logic [ERR_W-1:0] error_counter; // Failed start-ups and runtime errors
  logic limit_hit; // Retries used up
  assign limit_hit = error_counter >= RESET_COUNT_LIMIT;

  // Supply loss dominates everything, then the low power key
  always_comb begin
    next_state = state;
    if (lp_fail || core_fault) begin
      // RULE3 RULE4 shutdown
      next_state = frs_pkg::FRS_SHUTDOWN;
    end else if (lp_req && !shut) begin
      next_state = frs_pkg::FRS_LOW_POWER_OFF;
    end else begin
      case (state)
        frs_pkg::FRS_INIT: begin
          // RULE5 undervoltage pushes into self test
          if (uv || wake) next_state = frs_pkg::FRS_SELF_TEST;
        end
        frs_pkg::FRS_SELF_TEST: begin
          // RULE10 RULE16 start-up errors
          if (ot || crit) next_state = frs_pkg::FRS_ERROR;
          else if (st_ok) next_state = frs_pkg::FRS_THRESH_CHECK;
        end
        frs_pkg::FRS_THRESH_CHECK: begin
          // RULE1 RULE6 give up on a dead regulator clock
          if (rc_fail || uv) next_state = frs_pkg::FRS_LOW_POWER_OFF;
          else if (ot || crit) next_state = frs_pkg::FRS_ERROR;
          else if (thr_ok) next_state = frs_pkg::FRS_RAMP;
        end
        frs_pkg::FRS_RAMP: begin
          // RULE7 RULE10 RULE16 ramp faults
          if (uv || ot || crit) next_state = frs_pkg::FRS_ERROR;
          else if (ramp_ok) next_state = frs_pkg::FRS_ACTIVE;
        end
        frs_pkg::FRS_ACTIVE: begin
          // RULE2 RULE8 RULE11 RULE16 runtime faults
          if (rc_fail || uv || ot || crit) next_state = frs_pkg::FRS_ERROR;
        end
        frs_pkg::FRS_ERROR: begin
          // RULE23 stop retrying at the limit
          if (limit_hit) next_state = frs_pkg::FRS_LOW_POWER_OFF;
          // RULE10 RULE11 stay while the cause lasts
          else if (!(ot || uv || crit || rc_fail)) next_state = frs_pkg::FRS_INIT;
        end
        frs_pkg::FRS_LOW_POWER_OFF: begin
          // A fresh wake edge is needed so a stuck wake cannot loop retries
          if (wake_rise) next_state = frs_pkg::FRS_INIT;
        end
        frs_pkg::FRS_SHUTDOWN: next_state = frs_pkg::FRS_INIT;
        // RULE13 any other code restarts
        default: next_state = frs_pkg::FRS_INIT;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= frs_pkg::FRS_INIT;
    end else begin
      state <= next_state;
    end
  end

  // RULE25 saturating counter, cleared only by power-on
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      error_counter <= '0;
    end else if (shut) begin
      error_counter <= '0;
    end else if (next_state == frs_pkg::FRS_ERROR && state != frs_pkg::FRS_ERROR
                 && error_counter != {ERR_W{1'b1}}) begin
      // RULE16 count each entry into error
      error_counter <= ERR_W'(error_counter + 1'b1);
    end
  end

  // ****************************************
  // Reset, regulator and supply outputs
  // ****************************************
  logic sys_rst_n, per_rst_n, reg_en, ext_sel;

  // RULE14 RULE15 resets follow the next state so they never lag a fault
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sys_rst_n <= 1'b0;
      per_rst_n <= 1'b0;
      reg_en <= 1'b0;
    end else begin
      sys_rst_n <= next_state == frs_pkg::FRS_ACTIVE;
      // RULE13 regulators off outside ramp and active
      reg_en <= next_state == frs_pkg::FRS_RAMP || next_state == frs_pkg::FRS_ACTIVE;
      if (next_state != frs_pkg::FRS_ACTIVE) begin
        per_rst_n <= 1'b0;
      end else if (sys_rst_n && wdog_rise) begin
        // RULE15 latch on watchdog seen
        per_rst_n <= 1'b1;
      end
    end
  end

  // RULE12 hysteresis between the two comparator levels
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_sel <= 1'b0;
    end else if (state != frs_pkg::FRS_ACTIVE || ext_lo) begin
      ext_sel <= 1'b0;
    end else if (ext_hi) begin
      ext_sel <= 1'b1;
    end
  end

  assign SYSTEM_RESET_N = sys_rst_n;
  assign PERIPHERAL_RESET_N = per_rst_n;
  assign REG_ENABLE = reg_en;
  assign EXT_SUPPLY_SELECT = ext_sel;
  assign STATE = state;
  assign ERROR_COUNT = error_counter;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  chk_reset_active: assert property (sys_rst_n |-> state == frs_pkg::FRS_ACTIVE) // RULE14
    else $error("system reset released outside active");
  chk_periph_follows: assert property (per_rst_n |-> sys_rst_n && $past(sys_rst_n)) // RULE15
    else $error("peripheral reset ahead of system reset");
  chk_periph_watchdog: assert property ($rose(per_rst_n) |-> $past(wdog_rise)) // RULE15
    else $error("peripheral reset released without watchdog");
  chk_error_count: assert property ((state == frs_pkg::FRS_ACTIVE && (ot || crit) && !lp_fail // RULE16
    && !core_fault && !lp_req && error_counter < 4'h7) |=> state == frs_pkg::FRS_ERROR && !sys_rst_n
    && error_counter == $past(error_counter) + 1'b1) else $error("error entry not counted");
  chk_count_saturate: assert property ((&error_counter && !shut) |=> &error_counter) // RULE25
    else $error("error counter wrapped");
  chk_clock_loss: assert property ((state == frs_pkg::FRS_THRESH_CHECK && rc_fail && !lp_fail // RULE1
    && !core_fault && !lp_req) |=> state == frs_pkg::FRS_LOW_POWER_OFF) else $error("clock loss missed");
  chk_shutdown: assert property ((lp_fail || core_fault) |=> shut && !sys_rst_n && !per_rst_n // RULE3
    && system_status[frs_pkg::SYS_POR_BIT]) else $error("shutdown not entered");
  chk_invalid_code: assert property (!$onehot(state) |=> state == frs_pkg::FRS_INIT || shut) // RULE13
    else $error("invalid state kept");
  chk_parity_flag: assert property ((ser.frame_done && parity_bad) // RULE21
    |=> serial_status[frs_pkg::SER_PARITY_BIT] && $stable(ser.response)) else $error("parity not flagged");
  chk_capture_count: assert property (ser.frame_done && !shut // RULE19
    |=> capture[3:0] == 4'($past(ser.edge_count) - 5'h01)) else $error("capture wrong");
  chk_limit_stop: assert property ((state == frs_pkg::FRS_ERROR && limit_hit && !lp_fail // RULE23
    && !core_fault) |=> state == frs_pkg::FRS_LOW_POWER_OFF [*2]) else $error("retry past limit");

  cov_reach_active: cover property (state == frs_pkg::FRS_RAMP ##1 state == frs_pkg::FRS_ACTIVE);
  cov_periph_up: cover property ($rose(per_rst_n));
  cov_give_up: cover property (state == frs_pkg::FRS_ERROR ##1 state == frs_pkg::FRS_LOW_POWER_OFF);
  cov_key: cover property (lp_req);

endmodule : frs_supervisor

// File: testbench/frs_host_model.sv
// Host model: serial master of the supervisor link.
// Assumes one frame at a time, select idle between.
module frs_host_model (
  output logic sck,
  output logic csn,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock idles low, select idles high
  initial begin
    sck = 1'b0;
    csn = 1'b1;
    sdi = 1'b0;
  end
  // Frame of n clocks; reply sampled late in each high phase
  // word w is sent as given, top bit first
  task xfer(input logic [15:0] w, input int n, output logic fsb, output logic [15:0] rsp);
    #7 csn = 1'b0;
    #300 fsb = sdo;
    for (int i = 0; i < n; i++) begin
      sdi = w[15-i%16];
      #100 sck = 1'b1;
      #90 rsp = {rsp[14:0], sdo};
      #10 sck = 1'b0;
    end
    #190 rsp = {rsp[14:0], sdo};
    csn = 1'b1;
    // Released line must not keep its last bit
    sdi = ~sdi;
    #400;
  endtask : xfer
endmodule : frs_host_model

// File: testbench/test_frs_supervisor.sv
// Bench of the fault supervisor: state, resets, serial replies.
// Assumes frs_host_model drives the link pins.
module test_frs_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, sck, csn, sdi, sdo, srn, prn, sel, f, oe, ren;
  logic [12:0] c; // Fault and step levels
  logic [7:0] rail, st;
  logic [3:0] cnt;
  logic [15:0] r;
  int err_count, total_checks, cyc;
  int ft[4] = '{5, 8, 9, 10}; // Faults seen in active
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A deselected data line shows the inverse, so a sample taken outside the driven time is caught
  frs_host_model i_host (.sck(sck), .csn(csn), .sdi(sdi), .sdo(oe ? sdo : ~sdo));
  frs_supervisor i_dut (.CORE_CLK(clk), .RSTN(rstn), .SCK(sck), .CSN(csn), .SDI(sdi), .SDO(sdo),
    .SDO_OE(oe), .WATCHDOG_TRIGGER(c[0]), .WAKE(c[1]), .SELF_TEST_OK(c[2]), .THRESH_OK(c[3]),
    .RAMP_DONE(c[4]), .REG_CLK_FAIL(c[5]), .LOW_POWER_CLK_FAIL(c[6]), .CORE_SUPPLY_FAULT(c[7]),
    .INT_REG_UNDERVOLT(c[8]), .INT_REG_OVERTEMP(c[9]), .CRITICAL_ERROR(c[10]),
    .EXT_SUPPLY_ABOVE_HIGH(c[11]), .EXT_SUPPLY_BELOW_LOW(c[12]), .RAIL_FAULT(rail),
    .SYSTEM_RESET_N(srn), .PERIPHERAL_RESET_N(prn), .REG_ENABLE(ren), .EXT_SUPPLY_SELECT(sel),
    .STATE(st), .ERROR_COUNT(cnt));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Change one level, then let the samplers settle
  task set(input int i, input logic v);
    @(posedge clk);
    c[i] <= v;
    repeat (10) @(posedge clk);
  endtask : set
  // Bounded wait for a state
  task ws(input logic [7:0] s);
    for (int n = 0; n < 400 && st !== s; n++) @(posedge clk);
    chk(st, s);
  endtask : ws
  function automatic logic [15:0] frm(input logic [3:0] cmd, input logic [7:0] d);
    frm = {cmd, d, 4'h0};
    frm[0] = ~^frm[15:1];
  endfunction : frm
  // Request, then fetch the reply with a capture read, which clears no status
  task rd(input logic [3:0] cmd, input logic [15:0] exp);
    i_host.xfer(frm(cmd, 8'h00), 16, f, r);
    i_host.xfer(frm(4'h3, 8'h00), 16, f, r);
    chk(r, exp);
  endtask : rd
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    rstn = 1'b0;
    c = 13'h101E;
    rail = 8'h00;
    void'($urandom(1));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rail <= 8'(($urandom() & 32'hBF) | 32'h1);
    ws(8'h10);
    chk(srn, 1'b1);
    chk(ren, 1'b1);
    chk(prn, 1'b0);
    set(0, 1'b1);
    chk(prn, 1'b1);
    set(11, 1'b1);
    set(12, 1'b0);
    chk(sel, 1'b1);
    set(12, 1'b1);
    chk(sel, 1'b0);
    $display("test power-up done");
    rd(4'h1, {8'h00, rail});
    chk(f, 1'b1);
    chk(oe, 1'b0);
    rd(4'h3, 16'h000F);
    i_host.xfer(frm(4'h1, 8'h00), 17, f, r);
    rd(4'h3, 16'h0010);
    rd(4'h4, 16'h0004);
    i_host.xfer(frm(4'h1, 8'h00) ^ 16'h1, 16, f, r);
    rd(4'h4, 16'h0001);
    i_host.xfer(frm(4'h9, 8'h00), 16, f, r);
    rd(4'h4, 16'h0002);
    rd(4'h4, 16'h0000);
    $display("test serial done");
    for (int i = 1; i <= 7; i++) begin
      set(ft[i%4], 1'b1);
      chk(cnt, 16'(i));
      chk(st, i < 7 ? 8'h20 : 8'h40);
      chk(srn, 1'b0);
      chk(ren, 1'b0);
      set(ft[i%4], 1'b0);
      ws(i < 7 ? 8'h10 : 8'h40);
    end
    rd(4'h2, 16'h0003);
    rd(4'h1, {8'h00, rail | 8'h40});
    rd(4'h1, {8'h00, rail});
    $display("test errors done");
    set(1, 1'b0);
    set(1, 1'b1);
    ws(8'h10);
    i_host.xfer(frm(4'h5, 8'hAA), 16, f, r);
    ws(8'h40);
    set(6, 1'b1);
    chk(st, 8'h80);
    chk(cnt, 4'h0);
    chk(prn, 1'b0);
    set(6, 1'b0);
    set(7, 1'b1);
    chk(st, 8'h80);
    set(3, 1'b0);
    set(7, 1'b0);
    set(5, 1'b1);
    chk(st, 8'h40);
    chk(ren, 1'b0);
    $display("test shutdown done");
    end_of_test();
  end
endmodule : test_frs_supervisor
